// file: hdl/ccr_core_regs.sv
// codec core configuration registers with pointer-based control port
// ==========================================================
// Overview of operation
// (R1) Identification reads fixed part code high nibble, revision low nibble; writes ignored.
// (R2) pll_powerdown set holds the PLL in reset.
// (R3) adc_powerdown set holds the stereo ADC in reset.
// (R4) Host should change PLL/ADC power bits only when muted or powered down.
// (R5) Each dac_pair_powerdown bit independently holds its DAC pair in reset.
// (R6) global_powerdown resets to one, keeps registers; host clears it to run.
// (R7) dac_speed_range picks single, double or quad speed for playback converters.
// (R8) adc_speed_range picks the same speed ranges for the capture port.
// (R9) Host sets each speed range to match its port's real sample rate.
// (R10) adc_output_clock_select picks playback or capture port clocks for capture output.
// (R11) De-emphasis with auto rate only at 32, 44.1 or 48 kHz.
// (R12) With forced lock, deemphasis_rate selects rate; disabled means no de-emphasis.
// (R13) serial_format_select, reset 01, sets left, I2S or right-justified format.
// (R14) adc_single_line_mode picks serial format, one-line 1 or one-line 2.
// (R15) dac_single_line_mode picks the same choices for the playback port.
// (R16) right_justify_width zero gives 24-bit words, one gives 16-bit words.
// (R17) External converter bit clock is capture or playback bit clock by select bit, low only while the capture one-line code is zero.
// (R18) recovered_clock_tristate floats the recovered master clock output.
// (R19) update_hold stores volume, invert, mixing writes; applies them together on release.
// (R20) interpolation_rolloff_select zero fast roll-off, one slow roll-off.
// (R21) highpass_hold freezes the offset estimate and keeps subtracting it.
// (R22) Seven-bit pointer addresses registers; auto-increment advances it per access.
// (R23) All registers read-write except identification, which is read-only.
// (R24) Reserved bits read zero and writes to them do nothing.
`timescale 1ns/10ps
module ccr_core_regs
  import ccr_pkg::*;
(
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // control port byte stream
  input  wire logic             cpStart,
  input  wire logic             cpWrite,
  input  wire logic [7:0]       cpWrData,
  input  wire logic             cpRead,
  output logic      [7:0]       cpRdData,
  output logic                  cpRdValid,
  // status from the rest of the device
  input  wire logic             forcePllLock,
  input  wire logic [1:0]       deemphRateSel,
  input  wire logic [1:0]       autoRate,
  input  wire logic             captureBitClock,
  input  wire logic             playbackBitClock,
  input  wire logic             recoveredClockIn,
  // power and converter control
  output logic                  pllReset,
  output logic                  adcReset,
  output logic      [3:0]       dacPairReset,
  output logic                  lowPower,
  output logic      [1:0]       dacSpeedRange,
  output logic      [1:0]       adcSpeedRange,
  output logic                  adcOutputClockSelect,
  output logic      [1:0]       deemphRate,
  // serial formats and clocks
  output logic      [2:0]       captureFormat,
  output logic      [2:0]       playbackFormat,
  output logic                  rightJustify16,
  output logic                  extConverterBitClock,
  output logic                  recoveredMasterClockOut,
  output logic                  recoveredMasterClockOe,
  // filters and frozen registers
  output logic                  slowRolloff,
  output logic                  highpassHold,
  output logic      [12:0][7:0] appliedHoldRegs
);

  typedef struct packed {
    logic [6:0] pointer;
    logic       autoInc;
    logic       expectPtr;
    logic [7:0] power;
    logic [7:0] func;
    logic [7:0] format;
    logic [7:0] misc;
    logic [7:0] rdLocal;
    logic       rdFromMem;
    logic       rdStage;
    logic [7:0] rdData;
    logic       rdValid;
    logic       pllReset;
    logic       adcReset;
    logic [3:0] dacPairReset;
    logic       lowPower;
    logic [1:0] dacSpeed;
    logic [1:0] adcSpeed;
    logic       outClkSel;
    logic [1:0] deemph;
    logic [2:0] capFmt;
    logic [2:0] playFmt;
    logic       rj16;
    logic       extBitClk;
    logic       rmckOut;
    logic       rmckOe;
    logic       slow;
    logic       hpfHold;
  } ccr_core_s;

  localparam ccr_core_s CORE_RESET = '{
    pointer: PTR_RESET, autoInc: AUTOINC_RESET, expectPtr: 1'b1,
    power: POWER_RESET, func: FUNC_RESET, format: FORMAT_RESET, misc: MISC_RESET,
    rdLocal: 8'h00, rdFromMem: 1'b0, rdStage: 1'b0, rdData: 8'h00, rdValid: 1'b0,
    pllReset: 1'b0, adcReset: 1'b0, dacPairReset: 4'h0, lowPower: 1'b1,
    dacSpeed: 2'h0, adcSpeed: 2'h0, outClkSel: 1'b0, deemph: RATE_NONE,
    capFmt: FMT_I2S, playFmt: FMT_I2S, rj16: 1'b0, extBitClk: 1'b0,
    rmckOut: 1'b0, rmckOe: 1'b1, slow: 1'b0, hpfHold: 1'b0};

  ccr_core_s  q;
  ccr_core_s  next_q;
  logic       ptrByte;
  logic       dataWr;
  logic       access;
  logic       inHold;
  logic [3:0] holdIdx;
  logic [7:0] memRdData;

  // ==========================================================
  // serial format from single-line code and interface format
  function automatic logic [2:0] formatOf(input logic [1:0] lineMode, input logic [1:0] dif);
    logic [2:0] f;
    f = FMT_RESERVED;
    unique case (lineMode)
      2'h0:
      begin
        unique case (dif)
          2'h0: f = FMT_LEFT_JUST;  // R13
          2'h1: f = FMT_I2S;        // R13
          2'h2: f = FMT_RIGHT_JUST; // R13
          2'h3: f = FMT_RESERVED;
        endcase
      end
      2'h1: f = FMT_ONE_LINE1;
      2'h2: f = FMT_ONE_LINE2;
      2'h3: f = FMT_RESERVED;
    endcase
    return f;
  endfunction

  // start and first byte in one cycle make that byte the pointer
  assign ptrByte = cpWrite && (cpStart || q.expectPtr);
  assign dataWr  = cpWrite && !ptrByte;
  assign access  = dataWr || (cpRead && !cpWrite);
  assign inHold  = (q.pointer >= REG_HOLD_FIRST) && (q.pointer <= REG_HOLD_LAST);
  assign holdIdx = 4'(q.pointer - REG_HOLD_FIRST);

  // ==========================================================
  // frozen register bank
  ccr_hold_bank u_hold_bank (
    .clock   (clock),
    .rst     (rst),
    .wrEn    (dataWr && inHold),
    .wrAddr  (holdIdx),
    .wrData  (cpWrData),
    .rdAddr  (holdIdx),
    .rdData  (memRdData),
    .hold    (q.misc[MSC_HOLD]),
    .applied (appliedHoldRegs)
  );

  // ==========================================================
  // control port and register file
  always_comb
  begin
    next_q = q;
    if (cpStart)
    begin
      next_q.expectPtr = 1'b1;
    end
    if (ptrByte)
    begin
      next_q.pointer   = cpWrData[6:0]; // R22
      next_q.autoInc   = cpWrData[PTR_INC_BIT];
      next_q.expectPtr = 1'b0;
    end
    if (dataWr)
    begin
      unique case (q.pointer)
        REG_POWER:  next_q.power  = cpWrData & POWER_MASK;  // R24
        REG_FUNC:   next_q.func   = cpWrData & FUNC_MASK;   // R24
        REG_FORMAT: next_q.format = cpWrData & FORMAT_MASK; // R24
        REG_MISC:   next_q.misc   = cpWrData & MISC_MASK;   // R24
        default:    next_q.power  = q.power; // R23
      endcase
    end
    // read pipeline, two edges from request to data
    next_q.rdStage   = cpRead && !cpWrite;
    next_q.rdFromMem = inHold;
    unique case (q.pointer)
      REG_ID:     next_q.rdLocal = {PART_ID_CODE, REVISION_CODE}; // R1
      REG_POWER:  next_q.rdLocal = q.power;
      REG_FUNC:   next_q.rdLocal = q.func;
      REG_FORMAT: next_q.rdLocal = q.format;
      REG_MISC:   next_q.rdLocal = q.misc;
      default:    next_q.rdLocal = 8'h00;
    endcase
    next_q.rdValid = q.rdStage;
    next_q.rdData  = q.rdStage ? (q.rdFromMem ? memRdData : q.rdLocal) : q.rdData;
    if (access && q.autoInc)
    begin
      next_q.pointer = q.pointer + 7'h01; // R22
    end
    // control outputs
    next_q.pllReset     = q.power[POW_PLL];                       // R2
    next_q.adcReset     = q.power[POW_ADC];                       // R3
    next_q.dacPairReset = q.power[POW_DAC_HI:POW_DAC_LO];         // R5
    next_q.lowPower     = q.power[POW_GLOBAL];                    // R6
    next_q.dacSpeed     = q.func[FUN_DAC_HI:FUN_DAC_LO];          // R7
    next_q.adcSpeed     = q.func[FUN_ADC_HI:FUN_ADC_LO];          // R8
    next_q.outClkSel    = q.func[FUN_OUTCLK];                     // R10
    if (!q.func[FUN_DEEMPH])
    begin
      next_q.deemph = RATE_NONE; // R12
    end
    else if (!forcePllLock)
    begin
      next_q.deemph = autoRate; // R11
    end
    else
    begin
      next_q.deemph = deemphRateSel; // R12
    end
    next_q.capFmt  = formatOf(q.format[FMT_AOL_HI:FMT_AOL_LO], q.format[FMT_DIF_HI:FMT_DIF_LO]); // R14
    next_q.playFmt = formatOf(q.format[FMT_DOL_HI:FMT_DOL_LO], q.format[FMT_DIF_HI:FMT_DIF_LO]); // R15
    next_q.rj16    = q.format[FMT_RJ16]; // R16
    // external converter bit clock whenever the capture one-line code is nonzero, reserved code 3 included
    if (q.format[FMT_AOL_HI:FMT_AOL_LO] == 2'h0)
    begin
      next_q.extBitClk = 1'b0;
    end
    else
    begin
      next_q.extBitClk = q.misc[MSC_EXTCLK] ? playbackBitClock : captureBitClock; // R17
    end
    next_q.rmckOe  = !q.misc[MSC_HIZ];                              // R18
    next_q.rmckOut = recoveredClockIn && !q.misc[MSC_HIZ];          // R18
    next_q.slow    = q.misc[MSC_FILT];                              // R20
    next_q.hpfHold = q.misc[MSC_HPF];                               // R21
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      q <= CORE_RESET;
    end
    else
    begin
      q <= next_q;
    end
  end

  // ==========================================================
  // outputs
  assign cpRdData                = q.rdData;
  assign cpRdValid               = q.rdValid;
  assign pllReset                = q.pllReset;
  assign adcReset                = q.adcReset;
  assign dacPairReset            = q.dacPairReset;
  assign lowPower                = q.lowPower;
  assign dacSpeedRange           = q.dacSpeed;
  assign adcSpeedRange           = q.adcSpeed;
  assign adcOutputClockSelect    = q.outClkSel;
  assign deemphRate              = q.deemph;
  assign captureFormat           = q.capFmt;
  assign playbackFormat          = q.playFmt;
  assign rightJustify16          = q.rj16;
  assign extConverterBitClock    = q.extBitClk;
  assign recoveredMasterClockOut = q.rmckOut;
  assign recoveredMasterClockOe  = q.rmckOe;
  assign slowRolloff             = q.slow;
  assign highpassHold            = q.hpfHold;

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_pll_reset: assert property ((dataWr && q.pointer == REG_POWER) |-> ##2 pllReset == $past(cpWrData[6], 2)) // R2
    else $error("pll reset does not follow power register");
  a_adc_reset: assert property ((dataWr && q.pointer == REG_POWER) |-> ##2 adcReset == $past(cpWrData[5], 2)) // R3
    else $error("adc reset does not follow power register");
  a_dac_pairs: assert property ((dataWr && q.pointer == REG_POWER) |-> ##2 dacPairReset == $past(cpWrData[4:1], 2)) // R5
    else $error("dac pair resets do not follow power register");
  a_low_power: assert property ((dataWr && q.pointer == REG_POWER) |-> ##2 lowPower == $past(cpWrData[0], 2)) // R6
    else $error("low power does not follow global bit");
  a_id_fixed: assert property ((cpRead && !cpWrite && q.pointer == REG_ID) |-> // R1
    ##2 cpRdValid && cpRdData == {PART_ID_CODE, REVISION_CODE})
    else $error("identification read wrong");
  a_reserved_zero: assert property ((cpRead && !cpWrite && q.pointer == REG_POWER) |-> ##2 !cpRdData[7]) // R24
    else $error("reserved power bit reads one");
  a_ptr_pointer_autoincrement: assert property ((access && q.autoInc) |=> q.pointer == 7'($past(q.pointer) + 7'h01)) // R22
    else $error("pointer did not advance");
  a_recovered_master_clock_out_float: assert property (q.misc[MSC_HIZ] |=> !recoveredMasterClockOe && !recoveredMasterClockOut) // R18
    else $error("recovered clock driven while floated");
  a_deemph_off: assert property (!q.func[FUN_DEEMPH] |=> deemphRate == RATE_NONE) // R12
    else $error("de-emphasis active while disabled");
  a_auto_rate: assert property ((q.func[FUN_DEEMPH] && !forcePllLock) |=> deemphRate == $past(autoRate)) // R11
    else $error("de-emphasis not from detected rate");

  c_ptr_write: cover property ((cpStart && cpWrite) ##2 dataWr);
  c_read_id: cover property (cpRead && q.pointer == REG_ID ##2 cpRdValid);
  c_power_up: cover property (lowPower ##[1:20] !lowPower);

endmodule

// file: hdl/ccr_hold_bank.sv
// staged and applied copies of the volume, invert and mixing registers
`timescale 1ns/10ps
module ccr_hold_bank
  import ccr_pkg::*;
(
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst,
  // write and read port
  input  wire logic                   wrEn,
  input  wire logic [3:0]             wrAddr,
  input  wire logic [7:0]             wrData,
  input  wire logic [3:0]             rdAddr,
  output logic      [7:0]             rdData,
  // update freeze and applied values
  input  wire logic                   hold,
  output logic      [12:0][7:0]       applied
);

  typedef struct packed {
    logic [12:0][7:0] pending;
    logic [12:0][7:0] applied;
    logic [7:0]       rdData;
  } ccr_bank_s;

  localparam ccr_bank_s BANK_RESET = '{pending: HOLD_RESET, applied: HOLD_RESET, rdData: 8'h00};

  ccr_bank_s q;
  ccr_bank_s next_q;

  // ==========================================================
  // storage update
  always_comb
  begin
    next_q = q;
    for (int i = 0; i < HOLD_WORDS; i++)
    begin
      if (wrEn && (wrAddr == 4'(i)))
      begin
        next_q.pending[i] = wrData;
      end
    end
    // writes are stored always, applied only while not held
    if (!hold)
    begin
      next_q.applied = next_q.pending; // R19
    end
    next_q.rdData = (rdAddr < 4'(HOLD_WORDS)) ? q.pending[rdAddr] : 8'h00;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      q <= BANK_RESET;
    end
    else
    begin
      q <= next_q;
    end
  end

  assign rdData  = q.rdData;
  assign applied = q.applied;

  // ==========================================================
  // checks
  a_hold_freezes: assert property (@(posedge clock) disable iff (rst) hold |=> $stable(applied)) // R19
    else $error("applied values changed while held");
  a_release_applies: assert property (@(posedge clock) disable iff (rst) // R19
    (!hold && !wrEn) |=> applied == $past(q.pending))
    else $error("pending values not applied after release");
  c_hold_release: cover property (@(posedge clock) disable iff (rst) hold ##1 !hold);

endmodule

// file: hdl/ccr_pkg.sv
// constants for the codec core configuration register bank
package ccr_pkg;

  // ==========================================================
  // register offsets
  localparam logic [6:0] REG_ID     = 7'h01;
  localparam logic [6:0] REG_POWER  = 7'h02;
  localparam logic [6:0] REG_FUNC   = 7'h03;
  localparam logic [6:0] REG_FORMAT = 7'h04;
  localparam logic [6:0] REG_MISC   = 7'h05;
  localparam logic [6:0] REG_HOLD_FIRST = 7'h0F;
  localparam logic [6:0] REG_HOLD_LAST  = 7'h1B;
  localparam int         HOLD_WORDS     = 13;

  // ==========================================================
  // pointer byte layout and pointer reset
  localparam int         PTR_INC_BIT   = 7;
  localparam logic [6:0] PTR_RESET     = 7'h01;
  localparam logic       AUTOINC_RESET = 1'b1;

  // ==========================================================
  // identification, values arbitrary
  localparam logic [3:0] PART_ID_CODE  = 4'h9;
  localparam logic [3:0] REVISION_CODE = 4'h2;

  // ==========================================================
  // reset values and writable masks
  localparam logic [7:0] POWER_RESET  = 8'h01;
  localparam logic [7:0] FUNC_RESET   = 8'h00;
  localparam logic [7:0] FORMAT_RESET = 8'h40;
  localparam logic [7:0] MISC_RESET   = 8'h00;
  localparam logic [7:0] POWER_MASK   = 8'h7F;
  localparam logic [7:0] FUNC_MASK    = 8'hF6;
  localparam logic [7:0] FORMAT_MASK  = 8'hFD;
  localparam logic [7:0] MISC_MASK    = 8'hDF;
  localparam logic [7:0] VOL_RESET    = 8'h00;
  localparam logic [7:0] INV_RESET    = 8'h00;
  localparam logic [7:0] MIX_RESET    = 8'h09;
  localparam logic [12:0][7:0] HOLD_RESET =
    {MIX_RESET, MIX_RESET, MIX_RESET, MIX_RESET, INV_RESET, {8{VOL_RESET}}};

  // ==========================================================
  // field positions
  localparam int POW_PLL      = 6;
  localparam int POW_ADC      = 5;
  localparam int POW_DAC_HI   = 4;
  localparam int POW_DAC_LO   = 1;
  localparam int POW_GLOBAL   = 0;
  localparam int FUN_DAC_HI   = 7;
  localparam int FUN_DAC_LO   = 6;
  localparam int FUN_ADC_HI   = 5;
  localparam int FUN_ADC_LO   = 4;
  localparam int FUN_OUTCLK   = 2;
  localparam int FUN_DEEMPH   = 1;
  localparam int FMT_DIF_HI   = 7;
  localparam int FMT_DIF_LO   = 6;
  localparam int FMT_AOL_HI   = 5;
  localparam int FMT_AOL_LO   = 4;
  localparam int FMT_DOL_HI   = 3;
  localparam int FMT_DOL_LO   = 2;
  localparam int FMT_RJ16     = 0;
  localparam int MSC_EXTCLK   = 7;
  localparam int MSC_HIZ      = 6;
  localparam int MSC_HOLD     = 4;
  localparam int MSC_FILT     = 3;
  localparam int MSC_HPF      = 2;

  // ==========================================================
  // serial format numbers and de-emphasis rate codes
  localparam logic [2:0] FMT_LEFT_JUST  = 3'h0;
  localparam logic [2:0] FMT_I2S        = 3'h1;
  localparam logic [2:0] FMT_RIGHT_JUST = 3'h2;
  localparam logic [2:0] FMT_ONE_LINE1  = 3'h3;
  localparam logic [2:0] FMT_ONE_LINE2  = 3'h4;
  localparam logic [2:0] FMT_RESERVED   = 3'h7;
  localparam logic [1:0] RATE_NONE      = 2'h0;

endpackage

// file: verification/ccr_host_model.sv
// host controller model driving the control port byte stream
`timescale 1ns/10ps
module ccr_host_model
  import ccr_pkg::*;
(
  // clock
  input  wire logic       clock,
  // control port
  output logic            cpStart,
  output logic            cpWrite,
  output logic [7:0]      cpWrData,
  output logic            cpRead,
  input  wire logic [7:0] cpRdData,
  input  wire logic       cpRdValid
);
  // ==========================================================
  // idle levels, data bus inverted once a byte is done
  initial
  begin
    cpStart  = 1'b0;
    cpWrite  = 1'b0;
    cpWrData = 8'hA5;
    cpRead   = 1'b0;
  end

  // ==========================================================
  // pointer byte: autoinc in bit 7, address below
  task automatic setPtr(input logic [6:0] addr, input logic inc);
  begin
    @(posedge clock);
    #1;
    cpStart  = 1'b1;
    cpWrite  = 1'b1;
    cpWrData = {inc, addr};
    @(posedge clock);
    #1;
    cpStart  = 1'b0;
    cpWrite  = 1'b0;
    cpWrData = ~cpWrData;
  end
  endtask

  task automatic wrByte(input logic [7:0] data);
  begin
    @(posedge clock);
    #1;
    cpWrite  = 1'b1;
    cpWrData = data;
    @(posedge clock);
    #1;
    cpWrite  = 1'b0;
    cpWrData = ~cpWrData;
  end
  endtask

  // read one byte, waits a bounded time for the answer
  task automatic rdByte(output logic [7:0] data, output logic ok);
  begin
    ok   = 1'b0;
    data = 8'h00;
    @(posedge clock);
    #1;
    cpRead = 1'b1;
    @(posedge clock);
    #1;
    cpRead = 1'b0;
    repeat (6)
    begin
      if (!ok && cpRdValid === 1'b1)
      begin
        data = cpRdData;
        ok   = 1'b1;
      end
      else if (!ok)
      begin
        @(posedge clock);
        #1;
      end
    end
  end
  endtask
endmodule

// file: verification/tb_top.sv
// self-checking bench for the core configuration registers
`timescale 1ns/10ps
module tb_top
  import ccr_pkg::*;
();
  logic clock, rst, cpStart, cpWrite, cpRead, cpRdValid, forcePllLock, captureBitClock, playbackBitClock;
  logic recoveredClockIn, pllReset, adcReset, lowPower, adcOutputClockSelect, rightJustify16;
  logic extConverterBitClock, recoveredMasterClockOut, recoveredMasterClockOe, slowRolloff, highpassHold, ok;
  logic [7:0] cpWrData, cpRdData, d, pwr, fun, fmt, msc;
  logic [1:0] deemphRateSel, autoRate, dacSpeedRange, adcSpeedRange, deemphRate;
  logic [3:0] dacPairReset;
  logic [2:0] captureFormat, playbackFormat;
  logic [12:0][7:0] appliedHoldRegs, hv;
  logic [7:0] rstTab [5];
  integer seed, errorCnt, cmpCount, cycCnt, i, k;

  ccr_core_regs i_dut (.clock(clock), .rst(rst), .cpStart(cpStart), .cpWrite(cpWrite), .cpWrData(cpWrData),
    .cpRead(cpRead), .cpRdData(cpRdData), .cpRdValid(cpRdValid), .forcePllLock(forcePllLock),
    .deemphRateSel(deemphRateSel), .autoRate(autoRate), .captureBitClock(captureBitClock),
    .playbackBitClock(playbackBitClock), .recoveredClockIn(recoveredClockIn), .pllReset(pllReset),
    .adcReset(adcReset), .dacPairReset(dacPairReset), .lowPower(lowPower), .dacSpeedRange(dacSpeedRange),
    .adcSpeedRange(adcSpeedRange), .adcOutputClockSelect(adcOutputClockSelect), .deemphRate(deemphRate),
    .captureFormat(captureFormat), .playbackFormat(playbackFormat), .rightJustify16(rightJustify16),
    .extConverterBitClock(extConverterBitClock), .recoveredMasterClockOut(recoveredMasterClockOut),
    .recoveredMasterClockOe(recoveredMasterClockOe), .slowRolloff(slowRolloff), .highpassHold(highpassHold),
    .appliedHoldRegs(appliedHoldRegs));
  ccr_host_model i_host (.clock(clock), .cpStart(cpStart), .cpWrite(cpWrite), .cpWrData(cpWrData),
    .cpRead(cpRead), .cpRdData(cpRdData), .cpRdValid(cpRdValid));

  // ==========================================================
  // clock, timeout, checking
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock)
  begin
    cycCnt = cycCnt + 1;
    if (cycCnt == 30000)
    begin
      errorCnt = errorCnt + 1;
      wrapUp();
    end
  end

  task automatic check(input logic [103:0] seen, input logic [103:0] exp, input string msg);
  begin
    cmpCount = cmpCount + 1;
    if (seen !== exp)
    begin
      errorCnt = errorCnt + 1;
      $display("MISMATCH at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  end
  endtask

  task automatic wrapUp();
  begin
    $display("comparisons %0d mismatches %0d", cmpCount, errorCnt);
    if (errorCnt == 0 && cmpCount > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask

  // expected port format from one-line code and serial format code
  function automatic logic [2:0] fmtExp(input logic [1:0] ol, input logic [1:0] dif);
  begin
    if (ol == 2'h0)
      return (dif == 2'h3) ? 3'h7 : {1'b0, dif};
    return (ol == 2'h1) ? 3'h3 : (ol == 2'h2) ? 3'h4 : 3'h7;
  end
  endfunction

  task automatic settle();
  begin
    repeat (3) @(posedge clock);
    #1;
  end
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    seed = 32'hE2CF;
    {errorCnt, cmpCount, cycCnt} = '0;
    {forcePllLock, deemphRateSel, autoRate, captureBitClock, playbackBitClock, recoveredClockIn} = '0;
    rstTab = '{{PART_ID_CODE, REVISION_CODE}, 8'h01, 8'h00, 8'h40, 8'h00};
    rst = 1'b1;
    repeat (5) @(posedge clock);
    #1;
    rst = 1'b0;
    check(lowPower, 1'b1, "powerdown after reset");
    i_host.setPtr(REG_ID, 1'b1);
    for (i = 0; i < 5; i++)
    begin
      i_host.rdByte(d, ok);
      check({ok, d}, {1'b1, rstTab[i]}, "reset readout");
    end
    i_host.setPtr(REG_ID, 1'b0);
    i_host.wrByte(8'hFF);
    i_host.rdByte(d, ok);
    i_host.rdByte(d, ok);
    check({ok, d}, {1'b1, rstTab[0]}, "id after write");
    for (i = 0; i < 40; i++)
    begin
      {pwr, fun, fmt, msc} = (i == 0) ? '1 : (i == 1) ? '0 : $random(seed);
      pwr[0] = 1'b1;
      msc[4] = 1'b0;
      {forcePllLock, deemphRateSel, autoRate, captureBitClock, playbackBitClock, recoveredClockIn} = 8'($random(seed));
      i_host.setPtr(REG_POWER, 1'b1);
      i_host.wrByte(pwr);
      i_host.wrByte(fun);
      i_host.wrByte(fmt);
      i_host.wrByte(msc);
      settle();
      check({pllReset, adcReset, dacPairReset, lowPower}, pwr[6:0], "power");
      check({dacSpeedRange, adcSpeedRange}, fun[7:4], "speed");
      check(adcOutputClockSelect, fun[2], "out clock");
      check(deemphRate, !fun[1] ? 2'h0 : forcePllLock ? deemphRateSel : autoRate, "deemph");
      check(captureFormat, fmtExp(fmt[5:4], fmt[7:6]), "capture fmt");
      check(playbackFormat, fmtExp(fmt[3:2], fmt[7:6]), "playback fmt");
      check(rightJustify16, fmt[0], "rj width");
      check(extConverterBitClock, (fmt[5:4] == 2'h0) ? 1'b0 : msc[7] ? playbackBitClock : captureBitClock,
        "ext clk");
      check({recoveredMasterClockOe, recoveredMasterClockOut}, {!msc[6], recoveredClockIn & !msc[6]}, "recovered_master_clock_out");
      check({slowRolloff, highpassHold}, msc[3:2], "filters");
      i_host.setPtr(REG_POWER, 1'b1);
      i_host.rdByte(d, ok);
      check(d, pwr & 8'h7F, "power read");
      i_host.rdByte(d, ok);
      check(d, fun & 8'hF6, "func read");
      i_host.rdByte(d, ok);
      check(d, fmt & 8'hFD, "format read");
      i_host.rdByte(d, ok);
      check(d, msc & 8'hDF, "misc read");
    end
    i_host.setPtr(REG_MISC, 1'b0);
    i_host.wrByte(8'h10);
    i_host.setPtr(7'h0F, 1'b1);
    for (k = 0; k < 13; k++)
    begin
      hv[k] = 8'($random(seed));
      i_host.wrByte(hv[k]);
    end
    settle();
    check(appliedHoldRegs, {{4{8'h09}}, 8'h00, {8{8'h00}}}, "held");
    i_host.setPtr(REG_MISC, 1'b0);
    i_host.wrByte(8'h00);
    settle();
    check(appliedHoldRegs, hv, "released");
    i_host.setPtr(7'h0F, 1'b1);
    for (k = 0; k < 13; k++)
    begin
      i_host.rdByte(d, ok);
      check(d, hv[k], "staged read");
    end
    i_host.setPtr(7'h40, 1'b0);
    i_host.wrByte(8'h5A);
    i_host.rdByte(d, ok);
    check({ok, d}, 9'h100, "unmapped");
    i_host.setPtr(REG_POWER, 1'b0);
    i_host.wrByte(8'h00);
    settle();
    check(lowPower, 1'b0, "powerdown cleared");
    wrapUp();
  end
endmodule
